// File: logic/pif_cfg.svh
// Register offsets, field positions, reset values for the peripheral event flag block
`ifndef PIF_CFG_SVH
`define PIF_CFG_SVH
`define PIF_FLAGS_OFFSET  12'h000
`define PIF_MASK_OFFSET   12'h004
`define PIF_STATUS_OFFSET 12'h008
`define PIF_CONFIG_OFFSET 12'h00C
`define PIF_FLAGS_RESET   8'h00
`define PIF_MASK_RESET    8'h00
`define PIF_CONFIG_RESET  8'h00
`define PIF_BIT_PARALLEL  7
`define PIF_BIT_CONV      6
`define PIF_BIT_RX        5
`define PIF_BIT_TX        4
`define PIF_BIT_SYNC      3
`define PIF_BIT_CAPCMP    2
`define PIF_BIT_TIMER2    1
`define PIF_BIT_TIMER1    0
`define PIF_STICKY_MASK   8'hCF
`define PIF_CFG_NARROW    0
`endif

// File: logic/pif_pkg.sv
// Types shared by the peripheral event flag block
package pif_pkg;
  typedef enum logic [2:0] {
    CC_OFF_type_unused = 3'h0
  } unused_type;
  typedef enum logic [1:0] {
    CC_CAPTURE = 2'h0,
    CC_COMPARE = 2'h1,
    CC_PWM     = 2'h2
  } capcmp_mode_type;
  typedef struct packed {
    logic parallel_rw;
    logic conversion_done;
    logic rx_buffer_full;
    logic tx_buffer_empty;
    logic sync_transfer_done;
    logic i2c_master_cond_done;
    logic i2c_master_ack_done;
    logic bus_start_stop_idle;
    logic capture_event;
    logic compare_match;
    logic timer_two_match;
    logic timer_one_overflow;
  } events_type;
  typedef enum logic [2:0] {
    WR_IDLE = 3'b001,
    WR_RESP = 3'b010,
    WR_HOLD = 3'b100
  } wr_state_type;
endpackage

// File: logic/pif_event_merge.sv
// Folds peripheral event strobes into per-flag set requests
`timescale 1ns/1ps
`include "pif_cfg.svh"
module pif_event_merge
(
  // Event inputs and mode
  input  wire pif_pkg::events_type      ev,
  input  wire pif_pkg::capcmp_mode_type mode,
  // Per-flag set requests
  output logic [7:0]                    set_req
);
  import pif_pkg::*;
  always_comb
  begin
    set_req = 8'h00;
    set_req[`PIF_BIT_PARALLEL] = ev.parallel_rw;
    set_req[`PIF_BIT_CONV]     = ev.conversion_done;
    set_req[`PIF_BIT_SYNC]     = ev.sync_transfer_done | ev.i2c_master_cond_done
                               | ev.i2c_master_ack_done | ev.bus_start_stop_idle;
    // PWM leaves the flag alone
    case (mode)
      CC_CAPTURE: set_req[`PIF_BIT_CAPCMP] = ev.capture_event;
      CC_COMPARE: set_req[`PIF_BIT_CAPCMP] = ev.compare_match;
      default:    set_req[`PIF_BIT_CAPCMP] = 1'b0;
    endcase
    set_req[`PIF_BIT_TIMER2]   = ev.timer_two_match;
    set_req[`PIF_BIT_TIMER1]   = ev.timer_one_overflow;
  end
endmodule // pif_event_merge

// File: logic/pif_sync.sv
// Two-stage synchroniser for asynchronous level inputs
`timescale 1ns/1ps
module pif_sync
#(
  parameter int WIDTH = 2
)
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // Levels
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] stage;
  logic [WIDTH-1:0] next_stage;
  logic [WIDTH-1:0] next_q;
  always_comb
  begin
    next_stage = d;
    next_q     = stage;
  end
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      stage <= '0;
      q     <= '0;
    end
    else
    begin
      stage <= next_stage;
      q     <= next_q;
    end
  end
endmodule // pif_sync

// File: logic/peripheral_interrupt_flags.sv
// Peripheral event flag register with mask, interrupt and AXI4-Lite slave
//
// The AXI4-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
`include "pif_cfg.svh"
module peripheral_interrupt_flags
(
  // Clock and reset
  input  wire logic                      CLK,
  input  wire logic                      RESET,
  // Peripheral events, same clock
  input  wire pif_pkg::events_type       EVENTS,
  input  wire pif_pkg::capcmp_mode_type  CAPCMP_MODE,
  // Serial buffer levels, from the serial clock domain
  input  wire logic                      RX_BUFFER_FULL,
  input  wire logic                      TX_BUFFER_EMPTY,
  // Interrupt
  output logic                           IRQ,
  // AXI4-Lite write address
  input  wire logic [11:0]               AWADDR,
  input  wire logic                      AWVALID,
  output logic                           AWREADY,
  // AXI4-Lite write data
  input  wire logic [31:0]               WDATA,
  input  wire logic [3:0]                WSTRB,
  input  wire logic                      WVALID,
  output logic                           WREADY,
  // AXI4-Lite write response
  output logic [1:0]                     BRESP,
  output logic                           BVALID,
  input  wire logic                      BREADY,
  // AXI4-Lite read address
  input  wire logic [11:0]               ARADDR,
  input  wire logic                      ARVALID,
  output logic                           ARREADY,
  // AXI4-Lite read data
  output logic [31:0]                    RDATA,
  output logic [1:0]                     RRESP,
  output logic                           RVALID,
  input  wire logic                      RREADY
);
  import pif_pkg::*;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  logic [7:0]   set_req;
  logic [1:0]   levels;
  logic [7:0]   flags;
  logic [7:0]   next_flags;
  logic [7:0]   mask;
  logic [7:0]   next_mask;
  logic         narrow;
  logic         next_narrow;
  logic [7:0]   view;
  logic [7:0]   clear_req;

  logic         aw_held;
  logic         next_aw_held;
  logic [11:0]  aw_addr;
  logic [11:0]  next_aw_addr;
  logic         w_held;
  logic         next_w_held;
  logic [31:0]  w_data;
  logic [31:0]  next_w_data;
  logic [3:0]   w_strb;
  logic [3:0]   next_w_strb;
  logic         next_bvalid;
  logic [1:0]   next_bresp;
  logic         next_rvalid;
  logic [31:0]  next_rdata;
  logic [1:0]   next_rresp;
  logic         do_write;

  pif_event_merge merge
  (
    .ev      (EVENTS),
    .mode    (CAPCMP_MODE),
    .set_req (set_req)
  );

  // Buffer levels come from another clock, so they pass two flops
  pif_sync #(.WIDTH(2)) level_sync
  (
    .clk   (CLK),
    .reset (RESET),
    .d     ({RX_BUFFER_FULL, TX_BUFFER_EMPTY}),
    .q     (levels)
  );

  // Live view: bits 5 and 4 follow the buffers and cannot be cleared
  always_comb
  begin
    view                = flags;
    view[`PIF_BIT_RX]   = levels[1];
    view[`PIF_BIT_TX]   = levels[0];
  end

  // Write channel: address and data taken in either order
  always_comb
  begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held  = w_held;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = BVALID;
    next_bresp   = BRESP;
    do_write     = 1'b0;
    if (AWVALID && AWREADY)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = AWADDR;
    end
    if (WVALID && WREADY)
    begin
      next_w_held = 1'b1;
      next_w_data = WDATA;
      next_w_strb = WSTRB;
    end
    if (aw_held && w_held && !BVALID)
    begin
      do_write     = 1'b1;
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      case (aw_addr)
        `PIF_FLAGS_OFFSET, `PIF_MASK_OFFSET, `PIF_CONFIG_OFFSET: next_bresp = RESP_OKAY;
        default: next_bresp = RESP_SLVERR;
      endcase
    end
    else if (BVALID && BREADY)
    begin
      next_bvalid = 1'b0;
    end
  end

  assign AWREADY = !aw_held && !BVALID;
  assign WREADY  = !w_held && !BVALID;

  // Register state
  always_comb
  begin
    next_mask   = mask;
    next_narrow = narrow;
    clear_req   = 8'h00;
    if (do_write && w_strb[0])
    begin
      case (aw_addr)
        `PIF_FLAGS_OFFSET:  clear_req = w_data[7:0] & `PIF_STICKY_MASK;
        `PIF_MASK_OFFSET:   next_mask = w_data[7:0];
        `PIF_CONFIG_OFFSET: next_narrow = w_data[0];
        default:            clear_req = 8'h00;
      endcase
    end
    // Set wins over clear; no enable gates the set
    next_flags = ((flags & ~clear_req) | set_req) & `PIF_STICKY_MASK;
    // Narrow variant has no parallel port, bit 7 stays reserved
    if (next_narrow)
    begin
      next_flags[`PIF_BIT_PARALLEL] = 1'b0;
    end
  end

  // Read channel: one cycle from address to data
  always_comb
  begin
    next_rvalid = RVALID;
    next_rdata  = RDATA;
    next_rresp  = RRESP;
    if (ARVALID && ARREADY)
    begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OKAY;
      case (ARADDR)
        `PIF_FLAGS_OFFSET:  next_rdata = {24'h000000, view};
        `PIF_MASK_OFFSET:   next_rdata = {24'h000000, mask};
        `PIF_STATUS_OFFSET: next_rdata = {31'h0000000, IRQ};
        `PIF_CONFIG_OFFSET: next_rdata = {31'h0000000, narrow};
        default:
        begin
          next_rdata = 32'h00000000;
          next_rresp = RESP_SLVERR;
        end
      endcase
    end
    else if (RVALID && RREADY)
    begin
      next_rvalid = 1'b0;
    end
  end

  assign ARREADY = !RVALID;
  assign IRQ     = |(view & mask);

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      flags   <= `PIF_FLAGS_RESET;
      mask    <= `PIF_MASK_RESET;
      narrow  <= 1'b0;
      aw_held <= 1'b0;
      aw_addr <= 12'h000;
      w_held  <= 1'b0;
      w_data  <= 32'h00000000;
      w_strb  <= 4'h0;
      BVALID  <= 1'b0;
      BRESP   <= 2'h0;
      RVALID  <= 1'b0;
      RDATA   <= 32'h00000000;
      RRESP   <= 2'h0;
    end
    else
    begin
      flags   <= next_flags;
      mask    <= next_mask;
      narrow  <= next_narrow;
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held  <= next_w_held;
      w_data  <= next_w_data;
      w_strb  <= next_w_strb;
      BVALID  <= next_bvalid;
      BRESP   <= next_bresp;
      RVALID  <= next_rvalid;
      RDATA   <= next_rdata;
      RRESP   <= next_rresp;
    end
  end

  sequence clear_write_s;
    do_write && w_strb[0] && aw_addr == `PIF_FLAGS_OFFSET;
  endsequence

  // Both write channels taken on one edge; the response lags by a cycle
  sequence write_taken_s;
    AWVALID && AWREADY && WVALID && WREADY;
  endsequence

  parallel_set_a: assert property (@(posedge CLK) disable iff (RESET)
    EVENTS.parallel_rw && !next_narrow |=> flags[7])
    else $error("parallel flag not set");
  conv_set_a: assert property (@(posedge CLK) disable iff (RESET)
    EVENTS.conversion_done |=> flags[6])
    else $error("conversion flag not set");
  rx_level_a: assert property (@(posedge CLK) disable iff (RESET)
    RX_BUFFER_FULL [*3] |-> view[5])
    else $error("rx flag does not follow buffer");
  tx_level_a: assert property (@(posedge CLK) disable iff (RESET)
    !TX_BUFFER_EMPTY [*3] |-> !view[4])
    else $error("tx flag does not follow buffer");
  sync_set_a: assert property (@(posedge CLK) disable iff (RESET)
    EVENTS.sync_transfer_done |=> flags[3])
    else $error("sync flag not set");
  cond_set_a: assert property (@(posedge CLK) disable iff (RESET)
    EVENTS.i2c_master_cond_done |=> flags[3])
    else $error("cond flag not set");
  ack_set_a: assert property (@(posedge CLK) disable iff (RESET)
    EVENTS.i2c_master_ack_done |=> flags[3])
    else $error("ack flag not set");
  idle_set_a: assert property (@(posedge CLK) disable iff (RESET)
    EVENTS.bus_start_stop_idle |=> flags[3])
    else $error("bus idle flag not set");
  capture_set_a: assert property (@(posedge CLK) disable iff (RESET)
    CAPCMP_MODE == CC_CAPTURE && EVENTS.capture_event |=> flags[2])
    else $error("capture flag not set");
  pwm_quiet_a: assert property (@(posedge CLK) disable iff (RESET)
    CAPCMP_MODE == CC_PWM && !flags[2] |=> !flags[2])
    else $error("pwm set capcmp flag");
  timer_two_set_a: assert property (@(posedge CLK) disable iff (RESET)
    EVENTS.timer_two_match |=> flags[1])
    else $error("timer two flag not set");
  timer_one_hold_a: assert property (@(posedge CLK) disable iff (RESET)
    flags[0] && !(do_write && w_strb[0] && aw_addr == `PIF_FLAGS_OFFSET && w_data[0])
    |=> flags[0])
    else $error("timer one flag dropped");
  set_wins_a: assert property (@(posedge CLK) disable iff (RESET)
    clear_write_s ##0 (w_data[0] && EVENTS.timer_one_overflow) |=> flags[0])
    else $error("set lost to clear");
  irq_level_a: assert property (@(posedge CLK) disable iff (RESET)
    EVENTS.timer_one_overflow && mask[0] && next_mask[0] |=> IRQ)
    else $error("irq not raised");
  compare_set_a: assert property (@(posedge CLK) disable iff (RESET)
    CAPCMP_MODE == CC_COMPARE && EVENTS.compare_match |=> flags[2])
    else $error("compare flag not set");
  write_answer_a: assert property (@(posedge CLK) disable iff (RESET)
    write_taken_s |=> !BVALID ##1 BVALID)
    else $error("write response not timely");
  read_answer_a: assert property (@(posedge CLK) disable iff (RESET)
    ARVALID && ARREADY |=> RVALID)
    else $error("read data not timely");
endmodule // peripheral_interrupt_flags

// File: verif/event_source_model.sv
// Behavioural stand-in for the peripherals that raise events and buffer levels
`timescale 1ns/1ps
module event_source_model
(
  // Clock
  input  wire logic                clk,
  // Towards the flag block
  output pif_pkg::events_type      events,
  output pif_pkg::capcmp_mode_type capcmp_mode,
  output logic                     rx_buffer_full,
  output logic                     tx_buffer_empty
);
  import pif_pkg::*;
  logic [11:0] ev_bits = 12'h000;
  assign events = events_type'(ev_bits);
  initial
  begin
    capcmp_mode     = CC_CAPTURE;
    rx_buffer_full  = 1'b0;
    tx_buffer_empty = 1'b0;
  end
  // One-cycle strobe; callers start it just after an edge
  task automatic pulse(input int idx);
    begin
      ev_bits[idx] <= 1'b1;
      @(posedge clk);
      ev_bits[idx] <= 1'b0;
    end
  endtask
  task automatic set_mode(input capcmp_mode_type m);
    capcmp_mode <= m;
  endtask
  // Levels come from another domain in silicon; the block resynchronises them
  task automatic set_levels(input logic rx, input logic tx);
    begin
      rx_buffer_full  <= rx;
      tx_buffer_empty <= tx;
    end
  endtask
endmodule // event_source_model

// File: verif/peripheral_interrupt_flags_tb_top.sv
// Self-checking bench for the peripheral event flag block
`timescale 1ns/1ps
`include "pif_cfg.svh"
module peripheral_interrupt_flags_tb_top;
  import pif_pkg::*;
  logic clk = 1'b0, reset = 1'b1, irq;
  events_type ev;
  capcmp_mode_type mode;
  logic rxf, txe, awvalid = 0, awready, wvalid = 0, wready, bvalid, bready = 0;
  logic arvalid = 0, arready, rvalid, rready = 0;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, rd;
  logic [3:0]  wstrb = 0;
  logic [1:0]  bresp, rresp, resp;
  int n_mismatch = 0, comparisons = 0;
  always #2.5 clk = ~clk;
  event_source_model u_src (.clk(clk), .events(ev), .capcmp_mode(mode),
    .rx_buffer_full(rxf), .tx_buffer_empty(txe));
  peripheral_interrupt_flags u_dut (.CLK(clk), .RESET(reset), .EVENTS(ev), .CAPCMP_MODE(mode),
    .RX_BUFFER_FULL(rxf), .TX_BUFFER_EMPTY(txe), .IRQ(irq), .AWADDR(awaddr),
    .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid),
    .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr),
    .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid),
    .RREADY(rready));
  task automatic test_done;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    begin
      comparisons++;
      if (got !== exp)
      begin
        n_mismatch++;
        $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task automatic timed_out;
    begin
      n_mismatch++;
      $display("[ERR] bus wait expected answer seen none");
      test_done();
    end
  endtask
  // Address and data offered together, each released once taken
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    logic aw_done, w_done;
    begin
      aw_done = 0;
      w_done = 0;
      @(posedge clk);
      awaddr <= a; wdata <= d; wstrb <= s;
      awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      for (n = 0; n < 100; n++)
      begin
        @(posedge clk);
        if (bvalid === 1'b1 && aw_done && w_done) break;
        if (!aw_done && awready === 1'b1) begin aw_done = 1; awvalid <= 1'b0; end
        if (!w_done && wready === 1'b1) begin w_done = 1; wvalid <= 1'b0; end
      end
      if (n == 100) timed_out();
      resp = bresp;
      bready <= 1'b0;
    end
  endtask
  task automatic axi_read(input logic [11:0] a);
    int n;
    logic ar_done;
    begin
      ar_done = 0;
      @(posedge clk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      for (n = 0; n < 100; n++)
      begin
        @(posedge clk);
        if (rvalid === 1'b1 && ar_done) break;
        if (!ar_done && arready === 1'b1) begin ar_done = 1; arvalid <= 1'b0; end
      end
      if (n == 100) timed_out();
      rd = rdata;
      resp = rresp;
      rready <= 1'b0;
    end
  endtask
  task automatic expect_reg(input logic [11:0] a, input logic [31:0] exp);
    begin
      axi_read(a);
      check("register read", exp, rd);
      check("read response", 32'h0, {30'h0, resp});
    end
  endtask
  task automatic reset_values;
    begin
      expect_reg(`PIF_FLAGS_OFFSET, 32'h0);
      expect_reg(`PIF_MASK_OFFSET, 32'h0);
      expect_reg(`PIF_STATUS_OFFSET, 32'h0);
      expect_reg(`PIF_CONFIG_OFFSET, 32'h0);
    end
  endtask
  // Every event source, each cleared by software afterwards; mask stays zero
  task automatic sticky_sources;
    int evi[10] = '{11, 10, 7, 6, 5, 4, 3, 2, 1, 0};
    int bit_of[10] = '{7, 6, 3, 3, 3, 3, 2, 2, 1, 0};
    begin
      for (int i = 0; i < 10; i++)
      begin
        u_src.set_mode(capcmp_mode_type'(evi[i] == 2 ? CC_COMPARE : CC_CAPTURE));
        @(posedge clk);
        u_src.pulse(evi[i]);
        repeat (3) axi_read(`PIF_FLAGS_OFFSET);
        check("flag set", 32'h1 << bit_of[i], rd);
        check("irq unmasked only", 32'h0, {31'h0, irq});
        axi_write(`PIF_FLAGS_OFFSET, 32'h1 << bit_of[i], 4'hF);
        expect_reg(`PIF_FLAGS_OFFSET, 32'h0);
      end
    end
  endtask
  task automatic pwm_no_flag;
    begin
      u_src.set_mode(CC_PWM);
      @(posedge clk);
      u_src.pulse(3);
      u_src.pulse(2);
      expect_reg(`PIF_FLAGS_OFFSET, 32'h0);
      u_src.set_mode(CC_CAPTURE);
    end
  endtask
  task automatic buffer_levels;
    begin
      u_src.set_levels(1'b1, 1'b0);
      repeat (4) @(posedge clk);
      expect_reg(`PIF_FLAGS_OFFSET, 32'h20);
      u_src.set_levels(1'b0, 1'b1);
      repeat (4) @(posedge clk);
      axi_write(`PIF_FLAGS_OFFSET, 32'hFF, 4'hF);
      expect_reg(`PIF_FLAGS_OFFSET, 32'h10);
      u_src.set_levels(1'b0, 1'b0);
      repeat (4) @(posedge clk);
      expect_reg(`PIF_FLAGS_OFFSET, 32'h0);
    end
  endtask
  task automatic mask_and_irq;
    begin
      axi_write(`PIF_MASK_OFFSET, 32'hFFFFFFFF, 4'hF);
      check("write response", 32'h0, {30'h0, resp});
      expect_reg(`PIF_MASK_OFFSET, 32'hFF);
      axi_write(`PIF_MASK_OFFSET, 32'h0, 4'h0);
      expect_reg(`PIF_MASK_OFFSET, 32'hFF);
      axi_write(`PIF_MASK_OFFSET, 32'h01, 4'hF);
      check("irq idle", 32'h0, {31'h0, irq});
      u_src.pulse(0);
      expect_reg(`PIF_STATUS_OFFSET, 32'h1);
      check("irq raised", 32'h1, {31'h0, irq});
      axi_write(`PIF_FLAGS_OFFSET, 32'h01, 4'hF);
      check("irq cleared", 32'h0, {31'h0, irq});
      axi_write(`PIF_MASK_OFFSET, 32'h0, 4'hF);
    end
  endtask
  // Event lands on the edge at which the clear is applied
  task automatic set_beats_clear;
    begin
      fork
        axi_write(`PIF_FLAGS_OFFSET, 32'h01, 4'hF);
        begin
          int k;
          for (k = 0; k < 100; k++)
          begin
            @(posedge clk);
            if (awvalid === 1'b1 && awready === 1'b1) break;
          end
          if (k == 100) timed_out();
          u_src.pulse(0);
        end
      join
      expect_reg(`PIF_FLAGS_OFFSET, 32'h01);
      axi_write(`PIF_FLAGS_OFFSET, 32'h01, 4'hF);
    end
  endtask
  task automatic narrow_and_unmapped;
    begin
      axi_write(`PIF_CONFIG_OFFSET, 32'h1, 4'hF);
      expect_reg(`PIF_CONFIG_OFFSET, 32'h1);
      u_src.pulse(11);
      expect_reg(`PIF_FLAGS_OFFSET, 32'h0);
      axi_write(`PIF_CONFIG_OFFSET, 32'h0, 4'hF);
      axi_read(12'h010);
      check("unmapped read data", 32'h0, rd);
      check("unmapped read resp", 32'h2, {30'h0, resp});
      axi_write(12'h010, 32'h1, 4'hF);
      check("unmapped write resp", 32'h2, {30'h0, resp});
    end
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    reset_values();
    sticky_sources();
    pwm_no_flag();
    buffer_levels();
    mask_and_irq();
    set_beats_clear();
    narrow_and_unmapped();
    test_done();
  end
endmodule // peripheral_interrupt_flags_tb_top
